// file: hdl/adc_ctrl_pkg.sv
// Package with register map, field layout, reset values and carrier types of the converter block.
package adc_ctrl_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_MAIN_CONTROL      = 8'h00;
  localparam logic [7:0] OFS_FORMAT_CONTROL    = 8'h04;
  localparam logic [7:0] OFS_REFERENCE_CONTROL = 8'h08;
  localparam logic [7:0] OFS_EVENT_TRIGGER     = 8'h0c;
  localparam logic [7:0] OFS_CLOCK_DIVIDER     = 8'h10;
  localparam logic [7:0] OFS_INTERRUPT_FLAG    = 8'h14;
  localparam logic [7:0] OFS_BYTE_LATCH        = 8'h18;
  localparam logic [7:0] OFS_TRIM_LOW          = 8'h1c;
  localparam logic [7:0] OFS_TRIM_HIGH         = 8'h20;
  localparam logic [7:0] OFS_RESULT_LOW        = 8'h24;
  localparam logic [7:0] OFS_RESULT_HIGH       = 8'h28;
  localparam logic [7:0] OFS_THRESHOLD_LOW     = 8'h2c;
  localparam logic [7:0] OFS_THRESHOLD_HIGH    = 8'h30;
  localparam logic [7:0] OFS_CHANNEL_CONTROL   = 8'h34;
  localparam logic [7:0] OFS_CHANNEL_INT_CTRL  = 8'h38;

  // ==========================================================================
  // Field positions
  localparam int BIT_ENABLE       = 0;
  localparam int BIT_MAIN_START   = 2;
  localparam int BIT_SIGNEDNESS   = 4;
  localparam int BIT_FORMAT_LO    = 1;
  localparam int BIT_THERMAL      = 0;
  localparam int BIT_REF_HELPER   = 1;
  localparam int BIT_TRIG_ENABLE  = 0;
  localparam int BIT_TRIG_SEL_LO  = 3;
  localparam int BIT_FLAG         = 0;
  localparam int BIT_CHAN_START   = 7;
  localparam int BIT_GAIN_LO      = 2;
  localparam int BIT_INT_ENABLE   = 0;
  localparam int BIT_INT_MODE_LO  = 2;

  // ==========================================================================
  // Reset values and counts
  localparam logic [31:0] RST_RDATA        = 32'h0000_0000;
  localparam logic [11:0] RST_TRIM         = 12'h000;
  localparam logic [15:0] RST_WORD         = 16'h0000;
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [8:0]  DIV_HALF_BASE    = 9'h002;
  localparam logic [8:0]  RST_DIV_CNT      = 9'h000;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    FMT_RIGHT12 = 2'b00,
    FMT_RESV    = 2'b01,
    FMT_RIGHT8  = 2'b10,
    FMT_LEFT12  = 2'b11
  } result_format_t;

  typedef enum logic [1:0] {
    IN_INTERNAL             = 2'b00,
    IN_ONE_PIN_INPUT        = 2'b01,
    IN_TWO_PIN_INPUT        = 2'b10,
    IN_TWO_PIN_AMPLIFIED    = 2'b11
  } channel_input_select_t;

  typedef enum logic [1:0] {
    INT_COMPLETE = 2'b00,
    INT_BELOW    = 2'b01,
    INT_RESV     = 2'b10,
    INT_ABOVE    = 2'b11
  } int_mode_t;

  // ==========================================================================
  // Carriers toward and from the analog core
  typedef struct packed {
    logic                  adc_clk;
    logic                  conv_start;
    logic                  thermal_sense_enable;
    logic                  ref_helper_enable;
    logic [2:0]            gain_code;
    channel_input_select_t channel_input_select;
    logic                  signedness_select;
    logic                  neg_input_fixed;
    logic [11:0]           trim;
  } core_ctrl_t;

  typedef struct packed {
    logic        conv_done;
    logic        conv_busy;
    logic [11:0] conversion_result_bits;
  } core_stat_t;

endpackage : adc_ctrl_pkg

// file: hdl/adc_channel_control_regs.sv
// Register file and control logic of a single-channel converter on an AHB-Lite slave port.
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Reference helper bit enables reference generator
// - Thermal sense bit enables temperature source
// - Trigger selector picks event channel 0-3
// - Event trigger enable gates event starts
// - Clock divides by four doubling per code
// - Flag sets on completion or compare hit
// - Flag clears on vector or write one
// - Low byte read captures high byte
// - Twelve-bit trim across two byte registers
// - Left format puts bits high-aligned
// - Right format sign-extends for differential
// - Eight-bit format sign-extends when signed
// - Sixteen-bit threshold, signed in signed mode
// - Start bit starts, self-clears once begun
// - Both start bits share one storage
// - Gain field selects one to sixty-four, half
// - Unsigned mode: internal or one pin; code also accepts the two-pin codes in unsigned mode
// - Signed mode adds two-pin input modes
// - One-pin mode ties negative input fixed
// - Reserved bits read zero
// - Signedness bit selects unsigned or signed
// - Format code selects result layout
module adc_channel_control_regs
  import adc_ctrl_pkg::*;
#(
  parameter int EVENT_CHANNELS = 4
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic [EVENT_CHANNELS-1:0] event_in,
  input  wire logic        irq_ack,
  output var  logic        irq,
  input  wire core_stat_t  core_stat,
  output var  core_ctrl_t  core_ctrl
);

  if (EVENT_CHANNELS < 1 || EVENT_CHANNELS > 4)
  begin : g_bad_channels
    $error("EVENT_CHANNELS must lie between 1 and 4");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0]    hrdata;
    logic           hreadyout;
    logic           hresp;
    logic           wr_pend;
    logic [7:0]     wr_addr;
    logic           enable;
    logic           start;
    logic           signedness;
    result_format_t fmt;
    logic           thermal_en;
    logic           ref_en;
    logic [2:0]     trig_sel;
    logic           trig_en;
    logic [2:0]     div_code;
    logic [8:0]     div_cnt;
    logic           adc_clk;
    logic           flag;
    logic [7:0]     latch;
    logic [11:0]    trim;
    logic [15:0]    result;
    logic [15:0]    threshold;
    logic [2:0]     gain;
    channel_input_select_t in_mode;
    logic           int_en;
    int_mode_t      int_mode;
    logic           conv_start;
    logic           neg_fixed;
    logic           irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic        addr_ok;
  logic [7:0]  rd_byte;
  logic [15:0] fmt_word;
  logic        sign_ext;
  logic        cmp_below;
  logic        cmp_above;
  logic        cmp_hit;
  logic        event_hit;
  logic        start_set;
  logic [8:0]  div_half;
  logic [7:0]  wbyte;

  // ==========================================================================
  // Result formatting and compare
  always_comb
  begin
    sign_ext = 1'b0;
    fmt_word = RST_WORD;
    case (s_q.fmt)
      FMT_LEFT12:
      begin
        fmt_word = {core_stat.conversion_result_bits, 4'h0};
      end
      FMT_RIGHT8:
      begin
        sign_ext = s_q.signedness & core_stat.conversion_result_bits[7];
        fmt_word = {{8{sign_ext}}, core_stat.conversion_result_bits[7:0]};
      end
      default:
      begin
        sign_ext = s_q.signedness & s_q.in_mode[1] & core_stat.conversion_result_bits[11];
        fmt_word = {{4{sign_ext}}, core_stat.conversion_result_bits};
      end
    endcase
  end

  always_comb
  begin
    if (s_q.signedness)
    begin
      cmp_below = $signed(fmt_word) < $signed(s_q.threshold);
      cmp_above = $signed(fmt_word) > $signed(s_q.threshold);
    end
    else
    begin
      cmp_below = fmt_word < s_q.threshold;
      cmp_above = fmt_word > s_q.threshold;
    end
    case (s_q.int_mode)
      INT_BELOW: cmp_hit = cmp_below;
      INT_ABOVE: cmp_hit = cmp_above;
      INT_COMPLETE: cmp_hit = 1'b1;
      default: cmp_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // Event selection
  always_comb
  begin
    event_hit = 1'b0;
    if (s_q.trig_en && (int'(s_q.trig_sel) < EVENT_CHANNELS))
    begin
      event_hit = event_in[s_q.trig_sel[1:0]];
    end
  end

  // ==========================================================================
  // Read decode
  assign addr_ok = hsel & hready & htrans[1];

  always_comb
  begin
    case (haddr[7:0])
      OFS_MAIN_CONTROL:      rd_byte = {5'h00, s_q.start, 1'b0, s_q.enable};
      OFS_FORMAT_CONTROL:    rd_byte = {3'h0, s_q.signedness, 1'b0, s_q.fmt, 1'b0};
      OFS_REFERENCE_CONTROL: rd_byte = {6'h00, s_q.ref_en, s_q.thermal_en};
      OFS_EVENT_TRIGGER:     rd_byte = {2'h0, s_q.trig_sel, 2'h0, s_q.trig_en};
      OFS_CLOCK_DIVIDER:     rd_byte = {5'h00, s_q.div_code};
      OFS_INTERRUPT_FLAG:    rd_byte = {7'h00, s_q.flag};
      OFS_BYTE_LATCH:        rd_byte = s_q.latch;
      OFS_TRIM_LOW:          rd_byte = s_q.trim[7:0];
      OFS_TRIM_HIGH:         rd_byte = {4'h0, s_q.trim[11:8]};
      OFS_RESULT_LOW:        rd_byte = s_q.result[7:0];
      OFS_RESULT_HIGH:       rd_byte = s_q.result[15:8];
      OFS_THRESHOLD_LOW:     rd_byte = s_q.threshold[7:0];
      OFS_THRESHOLD_HIGH:    rd_byte = s_q.threshold[15:8];
      OFS_CHANNEL_CONTROL:   rd_byte = {s_q.start, 2'h0, s_q.gain, s_q.in_mode};
      OFS_CHANNEL_INT_CTRL:  rd_byte = {4'h0, s_q.int_mode, 1'b0, s_q.int_en};
      default:               rd_byte = RST_BYTE;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.conv_start = 1'b0;
    s_d.hreadyout = 1'b1;
    s_d.hresp = 1'b0;
    wbyte = hwdata[7:0];
    start_set = event_hit;
    div_half = DIV_HALF_BASE << s_q.div_code;

    // Address phase: read data is prepared for the following data phase.
    s_d.wr_pend = addr_ok & hwrite;
    s_d.wr_addr = haddr[7:0];
    if (addr_ok && !hwrite)
    begin
      s_d.hrdata = {24'h000000, rd_byte};
      case (haddr[7:0])
        OFS_TRIM_LOW:      s_d.latch = {4'h0, s_q.trim[11:8]};
        OFS_RESULT_LOW:    s_d.latch = s_q.result[15:8];
        OFS_THRESHOLD_LOW: s_d.latch = s_q.threshold[15:8];
        default:           s_d.latch = s_q.latch;
      endcase
    end

    // Data phase of a write.
    if (s_q.wr_pend)
    begin
      case (s_q.wr_addr)
        OFS_MAIN_CONTROL:
        begin
          s_d.enable = wbyte[BIT_ENABLE];
          start_set = start_set | wbyte[BIT_MAIN_START];
        end
        OFS_FORMAT_CONTROL:
        begin
          s_d.signedness = wbyte[BIT_SIGNEDNESS];
          s_d.fmt = result_format_t'(wbyte[BIT_FORMAT_LO+:2]);
        end
        OFS_REFERENCE_CONTROL:
        begin
          s_d.thermal_en = wbyte[BIT_THERMAL];
          s_d.ref_en = wbyte[BIT_REF_HELPER];
        end
        OFS_EVENT_TRIGGER:
        begin
          s_d.trig_sel = wbyte[BIT_TRIG_SEL_LO+:3];
          s_d.trig_en = wbyte[BIT_TRIG_ENABLE];
        end
        OFS_CLOCK_DIVIDER:     s_d.div_code = wbyte[2:0];
        OFS_BYTE_LATCH:        s_d.latch = wbyte;
        OFS_TRIM_LOW:          s_d.trim[7:0] = wbyte;
        OFS_TRIM_HIGH:         s_d.trim[11:8] = wbyte[3:0];
        OFS_THRESHOLD_LOW:     s_d.threshold[7:0] = wbyte;
        OFS_THRESHOLD_HIGH:    s_d.threshold[15:8] = wbyte;
        OFS_CHANNEL_CONTROL:
        begin
          start_set = start_set | wbyte[BIT_CHAN_START];
          s_d.gain = wbyte[BIT_GAIN_LO+:3];
          s_d.in_mode = channel_input_select_t'(wbyte[1:0]);
        end
        OFS_CHANNEL_INT_CTRL:
        begin
          s_d.int_en = wbyte[BIT_INT_ENABLE];
          s_d.int_mode = int_mode_t'(wbyte[BIT_INT_MODE_LO+:2]);
        end
        default:
        begin
        end
      endcase
    end

    // Start request: issued when enabled and the core is idle, then cleared; a new request wins.
    if (s_q.start && s_q.enable && !core_stat.conv_busy)
    begin
      s_d.conv_start = 1'b1;
      s_d.start = 1'b0;
    end
    if (start_set)
    begin
      s_d.start = 1'b1;
    end

    // Conversion clock divider, half period of two shifted by the code.
    if (s_q.enable)
    begin
      if (s_q.div_cnt >= div_half - 9'h001)
      begin
        s_d.div_cnt = RST_DIV_CNT;
        s_d.adc_clk = ~s_q.adc_clk;
      end
      else
      begin
        s_d.div_cnt = s_q.div_cnt + 9'h001;
      end
    end
    else
    begin
      s_d.div_cnt = RST_DIV_CNT;
      s_d.adc_clk = 1'b0;
    end

    // Result capture and interrupt flag; a setting event wins over any clear.
    if (irq_ack)
    begin
      s_d.flag = 1'b0;
    end
    if (s_q.wr_pend && (s_q.wr_addr == OFS_INTERRUPT_FLAG) && wbyte[BIT_FLAG])
    begin
      s_d.flag = 1'b0;
    end
    if (core_stat.conv_done)
    begin
      s_d.result = fmt_word;
      if (cmp_hit)
      begin
        s_d.flag = 1'b1;
      end
    end

    s_d.neg_fixed = (s_d.in_mode == IN_ONE_PIN_INPUT);
    s_d.irq = s_d.flag & s_d.int_en;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.hreadyout <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hreadyout;
  assign hresp = s_q.hresp;
  assign irq = s_q.irq;
  assign core_ctrl.adc_clk = s_q.adc_clk;
  assign core_ctrl.conv_start = s_q.conv_start;
  assign core_ctrl.thermal_sense_enable = s_q.thermal_en;
  assign core_ctrl.ref_helper_enable = s_q.ref_en;
  assign core_ctrl.gain_code = s_q.gain;
  assign core_ctrl.channel_input_select = s_q.in_mode;
  assign core_ctrl.signedness_select = s_q.signedness;
  assign core_ctrl.neg_input_fixed = s_q.neg_fixed;
  assign core_ctrl.trim = s_q.trim;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence read_of(logic [7:0] ofs);
    addr_ok && !hwrite && (haddr[7:0] == ofs);
  endsequence

  sequence write_data_of(logic [7:0] ofs);
    s_q.wr_pend && (s_q.wr_addr == ofs);
  endsequence

  a_start_issue: assert property (
    s_q.start && s_q.enable && !core_stat.conv_busy |=> core_ctrl.conv_start)
    else $error("start request not issued to core");

  a_irq_follow: assert property (
    irq == (s_q.flag && s_q.int_en))
    else $error("interrupt request missing");

  a_flag_on_done: assert property (
    core_stat.conv_done && s_q.int_mode == INT_COMPLETE |=> s_q.flag)
    else $error("flag not set on completion");

  a_flag_w1c: assert property (
    write_data_of(OFS_INTERRUPT_FLAG) ##0 hwdata[BIT_FLAG] && !core_stat.conv_done
      |=> !s_q.flag)
    else $error("flag not cleared by write of one");

  a_div_reserved: assert property (
    read_of(OFS_CLOCK_DIVIDER) |=> hrdata[31:3] == 29'h0 && hreadyout)
    else $error("reserved divider bits not zero");

  a_div_period: assert property (
    $rose(core_ctrl.adc_clk) && s_q.div_code == 3'h0 && s_q.enable
      ##1 s_q.div_code == 3'h0 && s_q.enable
      |-> core_ctrl.adc_clk ##1 !core_ctrl.adc_clk)
    else $error("divide-by-four period wrong");

  a_neg_tie: assert property (
    s_q.in_mode == IN_ONE_PIN_INPUT |-> core_ctrl.neg_input_fixed)
    else $error("negative input not tied in one-pin mode");

  a_latch_capture: assert property (
    read_of(OFS_RESULT_LOW) ##0 !(s_q.wr_pend && (s_q.wr_addr == OFS_BYTE_LATCH))
      |=> s_q.latch == $past(s_q.result[15:8]))
    else $error("high byte not captured");

  a_event_start: assert property (
    s_q.trig_en && s_q.trig_sel == 3'h0 && event_in[0] |=> s_q.start)
    else $error("event did not request conversion");

endmodule : adc_channel_control_regs

`default_nettype wire

// file: bench/conv_core_model.sv
// Behavioural model of the analog conversion core behind the control block.
`timescale 1ns/10ps
`default_nettype none
module conv_core_model
  import adc_ctrl_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire core_ctrl_t  core_ctrl,
  input  wire logic [7:0]  lat,
  input  wire logic [11:0] sample,
  output var  core_stat_t  core_stat
);
  // ====
  // Conversion timing
  logic [7:0]  cnt_q;
  logic [11:0] last_q;

  // Outside the done cycle the result lines show the inverse of the last result.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q     <= 8'h00;
      last_q    <= 12'h000;
      core_stat <= '0;
    end
    else
    begin
      core_stat.conv_done <= 1'b0;
      core_stat.conversion_result_bits <= ~last_q;
      if (core_ctrl.conv_start)
      begin
        cnt_q <= lat;
        core_stat.conv_busy <= 1'b1;
      end
      else if (cnt_q > 8'h01)
        cnt_q <= cnt_q - 8'h01;
      else if (core_stat.conv_busy)
      begin
        core_stat <= {1'b1, 1'b0, sample};
        last_q    <= sample;
      end
    end
  end
endmodule : conv_core_model
`default_nettype wire

// file: bench/adc_channel_control_regs_tb.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module adc_channel_control_regs_tb
  import adc_ctrl_pkg::*;
;
  // ====
  // Signals
  localparam int LIMIT = 20000;
  localparam logic [7:0] RWA [11] = '{OFS_FORMAT_CONTROL, OFS_REFERENCE_CONTROL,
    OFS_EVENT_TRIGGER, OFS_CLOCK_DIVIDER, OFS_BYTE_LATCH, OFS_TRIM_LOW, OFS_TRIM_HIGH,
    OFS_THRESHOLD_LOW, OFS_THRESHOLD_HIGH, OFS_CHANNEL_CONTROL, OFS_CHANNEL_INT_CTRL};
  localparam logic [7:0] RWM [11] = '{8'h16, 8'h03, 8'h39, 8'h07, 8'hff, 8'hff,
    8'h0f, 8'hff, 8'hff, 8'h1f, 8'h0d};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [3:0]  event_in = 4'h0;
  logic        irq_ack = 1'b0;
  logic        irq;
  logic [7:0]  lat = 8'h01;
  logic [11:0] sample = 12'h0;
  core_stat_t  core_stat;
  core_ctrl_t  core_ctrl;
  logic [31:0] seed = 32'h0000_c5e1;
  logic [31:0] rdata;
  logic        clk_prev = 1'b0;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          starts = 0;
  int          dones = 0;
  int          rises = 0;
  int          since = 0;
  int          per = 0;

  // ====
  // Design and core model
  adc_channel_control_regs u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .event_in(event_in),
    .irq_ack(irq_ack), .irq(irq), .core_stat(core_stat), .core_ctrl(core_ctrl)
  );
  conv_core_model u_core (
    .hclk(hclk), .hresetn(hresetn), .core_ctrl(core_ctrl), .lat(lat),
    .sample(sample), .core_stat(core_stat)
  );

  // ====
  // Clock and monitors
  always #12.5 hclk = ~hclk;

  // Counts start and done pulses and measures the converter clock period.
  always @(posedge hclk)
  begin
    cyc++;
    starts   <= starts + int'(core_ctrl.conv_start);
    dones    <= dones + int'(core_stat.conv_done);
    clk_prev <= core_ctrl.adc_clk;
    since    <= since + 1;
    if (core_ctrl.adc_clk && !clk_prev)
    begin
      rises <= rises + 1;
      per   <= since;
      since <= 1;
    end
    if (cyc == LIMIT)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ====
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [15:0] fmt(logic [11:0] r, logic [1:0] f, logic s, logic [1:0] m);
    case (f)
      2'b11: return {r, 4'h0};
      2'b10: return {{8{s & r[7]}}, r[7:0]};
      default: return {{4{s & m[1] & r[11]}}, r};
    endcase
  endfunction : fmt

  function automatic logic fl(logic [15:0] w, logic [15:0] t, logic s, logic [1:0] md);
    logic lo;
    lo = s ? ($signed(w) < $signed(t)) : (w < t);
    case (md)
      2'b00: return 1'b1;
      2'b01: return lo;
      2'b11: return !lo;
      default: return 1'b0;
    endcase
  endfunction : fl

  task automatic stop_test();
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdata = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rdata, {24'h0, e});
  endtask : rd

  task automatic wt(input int n);
    while (dones < n) @(posedge hclk);
  endtask : wt

  // ====
  // Main sequence
  initial
  begin : main
    logic [7:0]  v [11];
    logic [7:0]  d;
    logic [11:0] r;
    logic [15:0] w;
    logic [15:0] t;
    logic [1:0]  f;
    logic [1:0]  m;
    logic [1:0]  md;
    logic [2:0]  g;
    logic [2:0]  sel;
    logic [3:0]  hit;
    logic        s;
    logic        ie;
    logic        ef;
    int          n;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 64; a += 4)
      rd(8'(a), 8'h00);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 11; i++)
      begin
        d = 8'(rnd());
        if (RWA[i] == OFS_CHANNEL_CONTROL)
          d[7] = 1'b0;
        v[i] = d & RWM[i];
        wr(RWA[i], v[i]);
      end
      for (int i = 0; i < 11; i++)
        rd(RWA[i], v[i]);
      chk(32'(core_ctrl.thermal_sense_enable), 32'(v[1][0]));
      chk(32'(core_ctrl.ref_helper_enable), 32'(v[1][1]));
      chk(32'(core_ctrl.trim), {20'h0, v[6][3:0], v[5]});
      chk(32'(core_ctrl.signedness_select), 32'(v[0][4]));
      rd(OFS_TRIM_LOW, v[5]);
      rd(OFS_BYTE_LATCH, v[6]);
      rd(OFS_THRESHOLD_LOW, v[7]);
      rd(OFS_BYTE_LATCH, v[8]);
    end
    wr(OFS_EVENT_TRIGGER, 8'h00);
    wr(OFS_MAIN_CONTROL, 8'h01);
    for (int c = 0; c < 8; c++)
    begin
      wr(OFS_CLOCK_DIVIDER, 8'(c));
      n = rises + 2;
      while (rises < n) @(posedge hclk);
      chk(32'(per), 32'(4 << c));
    end
    wr(OFS_MAIN_CONTROL, 8'h04);
    wr(OFS_CHANNEL_CONTROL, 8'h80 | v[9]);
    rd(OFS_MAIN_CONTROL, 8'h04);
    rd(OFS_CHANNEL_CONTROL, 8'h80 | v[9]);
    n = starts;
    wr(OFS_MAIN_CONTROL, 8'h01);
    wt(dones + 1);
    rd(OFS_MAIN_CONTROL, 8'h01);
    rd(OFS_CHANNEL_CONTROL, v[9]);
    chk(32'(starts), 32'(n + 1));
    for (int k = 0; k < 24; k++)
    begin
      d = 8'(rnd());
      {ie, md, m, s, f} = d;
      d = 8'(rnd());
      g = d[2:0];
      lat <= 8'(d[7:3]) + 8'h01;
      r = 12'(rnd());
      t = 16'(rnd());
      sample <= r;
      w = fmt(r, f, s, m);
      if (w == t)
        t = ~t;
      ef = fl(w, t, s, md);
      wr(OFS_FORMAT_CONTROL, {3'b000, s, 1'b0, f, 1'b0});
      wr(OFS_THRESHOLD_LOW, t[7:0]);
      wr(OFS_THRESHOLD_HIGH, t[15:8]);
      wr(OFS_CHANNEL_INT_CTRL, {4'h0, md, 1'b0, ie});
      wr(OFS_INTERRUPT_FLAG, 8'h01);
      n = dones + 1;
      wr(OFS_CHANNEL_CONTROL, {1'b1, 2'b00, g, m});
      wt(n);
      rd(OFS_RESULT_LOW, w[7:0]);
      rd(OFS_BYTE_LATCH, w[15:8]);
      rd(OFS_RESULT_HIGH, w[15:8]);
      rd(OFS_INTERRUPT_FLAG, 8'(ef));
      chk(32'(irq), 32'(ef & ie));
      chk(32'(core_ctrl.gain_code), 32'(g));
      chk(32'(core_ctrl.channel_input_select), 32'(m));
      chk(32'(core_ctrl.neg_input_fixed), 32'(m == 2'b01));
      wr(OFS_INTERRUPT_FLAG, 8'h00);
      rd(OFS_INTERRUPT_FLAG, 8'(ef));
      if (k[0])
      begin
        irq_ack <= 1'b1;
        @(posedge hclk);
        irq_ack <= 1'b0;
      end
      else
        wr(OFS_INTERRUPT_FLAG, 8'h01);
      rd(OFS_INTERRUPT_FLAG, 8'h00);
    end
    lat <= 8'h02;
    for (int e = 0; e < 10; e++)
    begin
      sel = (e < 8) ? 3'(e / 2) : 3'b111;
      hit = 4'(1 << sel);
      wr(OFS_EVENT_TRIGGER, {2'b00, sel, 2'b00, e[0]});
      n = starts;
      event_in <= ~hit;
      @(posedge hclk);
      event_in <= 4'h0;
      repeat (20) @(posedge hclk);
      chk(32'(starts), 32'(n));
      event_in <= hit;
      @(posedge hclk);
      event_in <= 4'h0;
      repeat (20) @(posedge hclk);
      chk(32'(starts), 32'(n + int'(e[0] && sel != 3'b111)));
    end
    stop_test();
  end
endmodule : adc_channel_control_regs_tb
`default_nettype wire
